// ### pkg/cmdc_consts.svh
// register offsets, field positions, reset values and timing constants
`ifndef CMDC_CONSTS_SVH
`define CMDC_CONSTS_SVH

`define CMDC_ADDR_W          4
`define CMDC_OFF_CTRL        4'h0
`define CMDC_OFF_MULT        4'h4
`define CMDC_OFF_DCO         4'h8
`define CMDC_OFF_STAT        4'hc

`define CMDC_B_INT_ON        0
`define CMDC_B_INT_STABLE    1
`define CMDC_B_EXT_ON        2
`define CMDC_B_EXT_STABLE    3
`define CMDC_B_CLK_SEL       4
`define CMDC_B_MON_EN        5
`define CMDC_B_MON_FLAG      6
`define CMDC_B_MON_IRQ_EN    7

`define CMDC_MULT_W          7
`define CMDC_MULT_RST        7'h15
`define CMDC_BASE_KHZ_X10    3072

`define CMDC_STAGE_RST       8'h00
`define CMDC_DIV_RST         4'h0
`define CMDC_DIV_MAX         4'h9
`define CMDC_RING_MIN        5'h11
`define CMDC_FRAME_W         5
`define CMDC_COARSE_STEP     9'h020
`define CMDC_FINE_STEP       9'h001

`define CMDC_REF_DIV_SHORT   4
`define CMDC_REF_DIV_LONG    64
`define CMDC_MISS_LIMIT      2'h2

`endif

// ### pkg/cmdc_pkg.sv
// types shared by the clock monitor and oscillator control
package cmdc_pkg;
    typedef enum logic [1:0] {
        CMDC_SRC_INT_MON = 2'b00,
        CMDC_SRC_EXT_MON = 2'b01
    } cmdc_src_t;
    typedef logic [7:0] cmdc_stage_t;
    typedef logic [3:0] cmdc_div_t;
endpackage : cmdc_pkg

// ### design/cmdc_dco_quant.sv
// oscillator stage and divider codes with fine-adjust ring length choice
`timescale 1ns/1ns
`include "cmdc_consts.svh"
module cmdc_dco_quant (
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire logic             lf_up_i,
    input  wire logic             lf_down_i,
    input  wire logic             lf_coarse_i,
    input  wire logic             ring_tick_i,
    output cmdc_pkg::cmdc_stage_t stage_code_o,
    output cmdc_pkg::cmdc_div_t   divider_code_o,
    output logic [4:0]            ring_stages_o,
    output logic                  ring_half_o,
    output logic [3:0]            divider_shift_o
);
    cmdc_pkg::cmdc_stage_t stage_r;
    cmdc_pkg::cmdc_div_t   div_r;
    logic [4:0]            frame_r;
    logic [8:0]            step;
    logic [8:0]            sum;
    logic [8:0]            diff;
    logic                  long_cyc;

    function automatic logic [3:0] eff_div(input logic [3:0] c);
        eff_div = (c > `CMDC_DIV_MAX) ? `CMDC_DIV_MAX : c;
    endfunction : eff_div

    ////////////////////////////////////////////////////////////////////////
    assign step = lf_coarse_i ? `CMDC_COARSE_STEP : `CMDC_FINE_STEP;
    assign sum  = {1'b0, stage_r} + step;
    assign diff = {1'b0, stage_r} - step;

    // stage code; carries and borrows move the divider code by one, except at divider 9 or 0, where the stage code saturates
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            stage_r <= `CMDC_STAGE_RST;
            div_r   <= `CMDC_DIV_RST;
        end else if (lf_up_i && !lf_down_i) begin
            if (!sum[8]) begin
                stage_r <= sum[7:0];
            end else if (eff_div(div_r) < `CMDC_DIV_MAX) begin
                stage_r <= sum[7:0];
                div_r   <= eff_div(div_r) + 4'h1;
            end else begin
                stage_r <= 8'hff;
            end
        end else if (lf_down_i && !lf_up_i) begin
            if (!diff[8]) begin
                stage_r <= diff[7:0];
            end else if (eff_div(div_r) != 4'h0) begin
                stage_r <= diff[7:0];
                div_r   <= eff_div(div_r) - 4'h1;
            end else begin
                stage_r <= 8'h00;
            end
        end
    end

    // frame of 32 ring cycles
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_r <= 5'h00;
        end else if (ring_tick_i) begin
            frame_r <= frame_r + 5'h01;
        end
    end

    assign long_cyc = frame_r < stage_r[4:0];

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ring_stages_o <= `CMDC_RING_MIN;
            ring_half_o   <= 1'b0;
        end else if (stage_r[7:5] == 3'h7) begin
            ring_stages_o <= long_cyc ? `CMDC_RING_MIN : 5'h1f;
            ring_half_o   <= long_cyc;
        end else begin
            ring_stages_o <= `CMDC_RING_MIN + {1'b0, stage_r[7:5], 1'b0}
                             + (long_cyc ? 5'h02 : 5'h00);
            ring_half_o   <= 1'b0;
        end
    end

    assign stage_code_o    = stage_r;
    assign divider_code_o  = div_r;
    assign divider_shift_o = eff_div(div_r);
endmodule : cmdc_dco_quant

// ### design/cmdc_clock_monitor.sv
// clock monitor, source selection and register port of the clock generator
`timescale 1ns/1ns
`include "cmdc_consts.svh"
module cmdc_clock_monitor #(
    parameter int REF_DIV_SHORT = `CMDC_REF_DIV_SHORT,
    parameter int REF_DIV_LONG  = `CMDC_REF_DIV_LONG
) (
    input  wire logic                   mclk_i,
    input  wire logic                   rst_i,
    input  wire logic [`CMDC_ADDR_W-1:0] reg_addr_i,
    input  wire logic [7:0]             reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic [7:0]                  reg_rdata_o,
    input  wire logic                   base_clock_i,
    input  wire logic                   external_clock_i,
    input  wire logic                   int_filter_stable_i,
    input  wire logic                   ext_stab_done_i,
    input  wire logic                   slow_external_config_i,
    input  wire logic                   lf_up_i,
    input  wire logic                   lf_down_i,
    input  wire logic                   lf_coarse_i,
    input  wire logic                   ring_tick_i,
    output logic                        int_gen_on_o,
    output logic                        ext_gen_on_o,
    output logic                        osc_sel_ext_o,
    output logic                        timebase_sel_ext_o,
    output logic [`CMDC_MULT_W-1:0]     multiply_factor_o,
    output logic                        monitor_irq_o,
    output logic [4:0]                  ring_stages_o,
    output logic                        ring_half_o,
    output logic [3:0]                  divider_shift_o
);
    // index 0 watches the internal base clock, index 1 the external clock
    logic [1:0]  pin_meta_r;
    logic [1:0]  pin_sync_r;
    logic [1:0]  pin_prev_r;
    logic [1:0]  stb_meta_r;
    logic [1:0]  stb_sync_r;
    logic [1:0]  fall;
    logic [11:0] ref_cnt_r [2];
    logic [1:0]  ref_r;
    logic [1:0]  ref_prev_r;
    logic [1:0]  seen_r;
    logic [1:0]  miss_r [2];
    logic [1:0]  inactive_r;
    logic [1:0]  gen_on;
    logic [1:0]  stable;

    logic        int_on_r;
    logic        ext_on_r;
    logic        clk_sel_r;
    logic        mon_en_r;
    logic        mon_flag_r;
    logic        irq_en_r;
    logic        clr_armed_r;
    logic [`CMDC_MULT_W-1:0] mult_r;

    logic        wr_ctrl;
    logic        rd_ctrl;
    logic        mon_event;
    logic [7:0]  ctrl_val;
    logic [7:0]  rdata_nxt;
    cmdc_pkg::cmdc_stage_t stage_code;
    cmdc_pkg::cmdc_div_t   divider_code;

    function automatic logic [11:0] ref_div(input logic long_div);
        ref_div = long_div ? 12'(REF_DIV_LONG - 1) : 12'(REF_DIV_SHORT - 1);
    endfunction : ref_div

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers for pins from other clock domains
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_meta_r <= 2'b00;
            pin_sync_r <= 2'b00;
            pin_prev_r <= 2'b00;
            stb_meta_r <= 2'b00;
            stb_sync_r <= 2'b00;
        end else begin
            pin_meta_r <= {external_clock_i, base_clock_i};
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
            stb_meta_r <= {ext_stab_done_i, int_filter_stable_i};
            stb_sync_r <= stb_meta_r;
        end
    end

    assign fall   = pin_prev_r & ~pin_sync_r;
    assign gen_on = {ext_on_r, int_on_r};
    assign stable = stb_sync_r & gen_on & ~inactive_r;

    ////////////////////////////////////////////////////////////////////////
    // references: each clock divided down to watch the other one
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ref_cnt_r[0] <= 12'h000;
            ref_cnt_r[1] <= 12'h000;
            ref_r        <= 2'b00;
        end else begin
            for (int j = 0; j < 2; j++) begin
                if (!gen_on[j]) begin
                    ref_cnt_r[j] <= 12'h000;
                    ref_r[j]     <= 1'b0;
                end else if (fall[j]) begin
                    // the slow side gets the short divider
                    if (ref_cnt_r[j] ==
                        ref_div((j == 0) == slow_external_config_i)) begin
                        ref_cnt_r[j] <= 12'h000;
                        ref_r[j]     <= ~ref_r[j];
                    end else begin
                        ref_cnt_r[j] <= ref_cnt_r[j] + 12'h001;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // activity detectors
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ref_prev_r <= 2'b00;
            seen_r     <= 2'b00;
            miss_r[0]  <= 2'h0;
            miss_r[1]  <= 2'h0;
            inactive_r <= 2'b00;
        end else begin
            ref_prev_r <= ref_r;
            for (int i = 0; i < 2; i++) begin
                if (!gen_on[0] || !gen_on[1]) begin
                    seen_r[i]     <= 1'b0;
                    miss_r[i]     <= 2'h0;
                    inactive_r[i] <= 1'b0;
                end else if (!ref_r[1 - i] && fall[i]) begin
                    seen_r[i]     <= 1'b1;
                    miss_r[i]     <= 2'h0;
                    inactive_r[i] <= 1'b0;
                end else if (ref_r[1 - i] && !ref_prev_r[1 - i]) begin
                    seen_r[i] <= 1'b0;
                    if (!seen_r[i]) begin
                        if (miss_r[i] == `CMDC_MISS_LIMIT - 2'h1) begin
                            inactive_r[i] <= 1'b1;
                            miss_r[i]     <= `CMDC_MISS_LIMIT;
                        end else if (miss_r[i] != `CMDC_MISS_LIMIT) begin
                            miss_r[i] <= miss_r[i] + 2'h1;
                        end
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register port decode
    assign wr_ctrl   = reg_wr_i && reg_addr_i == `CMDC_OFF_CTRL;
    assign rd_ctrl   = reg_rd_i && reg_addr_i == `CMDC_OFF_CTRL;
    assign mon_event = mon_en_r && (inactive_r != 2'b00);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            int_on_r <= 1'b1;
            ext_on_r <= 1'b0;
            irq_en_r <= 1'b0;
        end else if (wr_ctrl) begin
            int_on_r <= reg_wdata_i[`CMDC_B_INT_ON];
            ext_on_r <= reg_wdata_i[`CMDC_B_EXT_ON];
            irq_en_r <= reg_wdata_i[`CMDC_B_MON_IRQ_EN];
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mon_en_r <= 1'b0;
        end else if (wr_ctrl) begin
            if (!reg_wdata_i[`CMDC_B_MON_EN]) begin
                mon_en_r <= 1'b0;
            end else if (gen_on == 2'b11 && stable == 2'b11) begin
                mon_en_r <= 1'b1;
            end
        end
        // no path clears it on loss of stability
    end

    // clock select: forced by the monitor, else written when both generators on and target stable
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            clk_sel_r <= 1'b0;
        end else if (mon_en_r && inactive_r[0]) begin
            clk_sel_r <= 1'b1;
        end else if (mon_en_r && inactive_r[1]) begin
            clk_sel_r <= 1'b0;
        end else if (wr_ctrl && gen_on == 2'b11 &&
                     stable[reg_wdata_i[`CMDC_B_CLK_SEL]]) begin
            clk_sel_r <= reg_wdata_i[`CMDC_B_CLK_SEL];
        end
    end

    // flag clear needs a read that saw it set, then a zero write
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mon_flag_r  <= 1'b0;
            clr_armed_r <= 1'b0;
        end else if (mon_event) begin
            mon_flag_r <= 1'b1;
        end else if (wr_ctrl && clr_armed_r &&
                     !reg_wdata_i[`CMDC_B_MON_FLAG]) begin
            mon_flag_r  <= 1'b0;
            clr_armed_r <= 1'b0;
        end else if (rd_ctrl && mon_flag_r) begin
            clr_armed_r <= 1'b1;
        end
        // a one written to the flag is ignored
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mult_r <= `CMDC_MULT_RST;
        end else if (reg_wr_i && reg_addr_i == `CMDC_OFF_MULT) begin
            mult_r <= reg_wdata_i[`CMDC_MULT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the read strobe
    always_comb begin
        ctrl_val = 8'h00;
        ctrl_val[`CMDC_B_INT_ON]     = int_on_r;
        ctrl_val[`CMDC_B_INT_STABLE] = stable[0];
        ctrl_val[`CMDC_B_EXT_ON]     = ext_on_r;
        ctrl_val[`CMDC_B_EXT_STABLE] = stable[1];
        ctrl_val[`CMDC_B_CLK_SEL]    = clk_sel_r;
        ctrl_val[`CMDC_B_MON_EN]     = mon_en_r;
        ctrl_val[`CMDC_B_MON_FLAG]   = mon_flag_r;
        ctrl_val[`CMDC_B_MON_IRQ_EN] = irq_en_r;
        unique case (reg_addr_i)
            `CMDC_OFF_CTRL: rdata_nxt = ctrl_val;
            `CMDC_OFF_MULT: rdata_nxt = {1'b0, mult_r};
            `CMDC_OFF_DCO:  rdata_nxt = stage_code;
            `CMDC_OFF_STAT: rdata_nxt = {2'b00, divider_code, inactive_r};
            default:        rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_nxt;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    cmdc_dco_quant u_dco (
        .mclk_i          (mclk_i),
        .rst_i           (rst_i),
        .lf_up_i         (lf_up_i),
        .lf_down_i       (lf_down_i),
        .lf_coarse_i     (lf_coarse_i),
        .ring_tick_i     (ring_tick_i),
        .stage_code_o    (stage_code),
        .divider_code_o  (divider_code),
        .ring_stages_o   (ring_stages_o),
        .ring_half_o     (ring_half_o),
        .divider_shift_o (divider_shift_o)
    );

    assign int_gen_on_o       = int_on_r;
    assign ext_gen_on_o       = ext_on_r;
    assign osc_sel_ext_o      = clk_sel_r;
    assign timebase_sel_ext_o = ext_on_r && !(mon_en_r && inactive_r[1]);
    assign multiply_factor_o  = mult_r;
    assign monitor_irq_o      = mon_flag_r && irq_en_r;
endmodule : cmdc_clock_monitor

// ### tb/cmdc_clock_monitor_checker.sv
// concurrent checks on the clock monitor top-level ports
`timescale 1ns/1ns
`include "cmdc_consts.svh"
module cmdc_clock_monitor_checker #(
    parameter int REF_DIV_SHORT = 4,
    parameter int REF_DIV_LONG  = 64
) (
    input wire logic       mclk_i,
    input wire logic       rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       lf_up_i,
    input wire logic       lf_down_i,
    input wire logic       ext_gen_on_o,
    input wire logic       osc_sel_ext_o,
    input wire logic [6:0] multiply_factor_o,
    input wire logic       monitor_irq_o,
    input wire logic [4:0] ring_stages_o,
    input wire logic       ring_half_o,
    input wire logic [3:0] divider_shift_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    wire logic ctrl_rd = reg_rd_i && (reg_addr_i == `CMDC_OFF_CTRL);
    wire logic ctrl_wr = reg_wr_i && (reg_addr_i == `CMDC_OFF_CTRL);

    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data not zero outside read answer");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i[1:0] != 2'h0
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    a_sel_readback: assert property (ctrl_rd |=>
        reg_rdata_o[4] == $past(osc_sel_ext_o)
        && reg_rdata_o[2] == $past(ext_gen_on_o))
        else $error("select readback mismatch");
    a_irq_readback: assert property (ctrl_rd |=>
        (reg_rdata_o[6] & reg_rdata_o[7]) == $past(monitor_irq_o))
        else $error("irq not flag and enable");
    a_sel_needs_on: assert property (ctrl_wr && !ext_gen_on_o
        |=> $stable(osc_sel_ext_o)) else $error("select moved with ext off");
    a_mult_write: assert property (reg_wr_i
        && reg_addr_i == `CMDC_OFF_MULT
        |=> multiply_factor_o == $past(reg_wdata_i[6:0]))
        else $error("multiply factor write lost");
    a_ring_range: assert property (ring_stages_o[0]
        && ring_stages_o >= 5'h11) else $error("ring length out of range");
    a_half_short: assert property (ring_half_o |-> ring_stages_o == 5'h11)
        else $error("divide by two without short ring");
    a_shift_cap: assert property (divider_shift_o <= 4'h9)
        else $error("divider shift above nine");
    a_shift_cause: assert property ($changed(divider_shift_o)
        |-> $past(lf_up_i ^ lf_down_i)) else $error("divider moved alone");
endmodule : cmdc_clock_monitor_checker

bind cmdc_clock_monitor cmdc_clock_monitor_checker #(
    .REF_DIV_SHORT(REF_DIV_SHORT),
    .REF_DIV_LONG (REF_DIV_LONG)
) i_chk (
    .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .lf_up_i(lf_up_i), .lf_down_i(lf_down_i),
    .ext_gen_on_o(ext_gen_on_o), .osc_sel_ext_o(osc_sel_ext_o),
    .multiply_factor_o(multiply_factor_o), .monitor_irq_o(monitor_irq_o),
    .ring_stages_o(ring_stages_o), .ring_half_o(ring_half_o),
    .divider_shift_o(divider_shift_o)
);

// ### tb/cmdc_clock_monitor_tb.sv
// self-checking bench for the clock monitor and oscillator control
`timescale 1ns/1ns
`include "cmdc_consts.svh"
module cmdc_clock_monitor_tb;
    logic       mclk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic       base_clock_i = 1'b0, external_clock_i = 1'b0;
    logic       int_filter_stable_i = 1'b1, ext_stab_done_i = 1'b0;
    logic       lf_up_i = 1'b0, lf_down_i = 1'b0, lf_coarse_i = 1'b0;
    logic       ring_tick_i = 1'b0;
    logic       base_run = 1'b1, ext_run = 1'b1;
    logic [7:0] reg_rdata_o;
    logic       int_gen_on_o, ext_gen_on_o, osc_sel_ext_o;
    logic       timebase_sel_ext_o, monitor_irq_o, ring_half_o;
    logic [6:0] multiply_factor_o;
    logic [4:0] ring_stages_o;
    logic [3:0] divider_shift_o;
    int         checks = 0, miscompares = 0;

    cmdc_clock_monitor #(.REF_DIV_SHORT(2), .REF_DIV_LONG(4)) i_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .base_clock_i(base_clock_i),
        .external_clock_i(external_clock_i),
        .int_filter_stable_i(int_filter_stable_i),
        .ext_stab_done_i(ext_stab_done_i),
        .slow_external_config_i(1'b0),
        .lf_up_i(lf_up_i), .lf_down_i(lf_down_i), .lf_coarse_i(lf_coarse_i),
        .ring_tick_i(ring_tick_i), .int_gen_on_o(int_gen_on_o),
        .ext_gen_on_o(ext_gen_on_o), .osc_sel_ext_o(osc_sel_ext_o),
        .timebase_sel_ext_o(timebase_sel_ext_o),
        .multiply_factor_o(multiply_factor_o), .monitor_irq_o(monitor_irq_o),
        .ring_stages_o(ring_stages_o), .ring_half_o(ring_half_o),
        .divider_shift_o(divider_shift_o)
    );

    initial begin
        forever #2 mclk_i = ~mclk_i;
    end
    // base clock has a 32 ns period, external clock 48 ns
    initial begin
        forever begin
            repeat (4) @(posedge mclk_i);
            if (base_run) base_clock_i <= ~base_clock_i;
        end
    end
    initial begin
        forever begin
            repeat (6) @(posedge mclk_i);
            if (ext_run) external_clock_i <= ~external_clock_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i    <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i   <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : rd

    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask : rchk

    task automatic step(input logic up, input logic coarse, input int n);
        repeat (n) begin
            @(posedge mclk_i);
            lf_up_i     <= up;
            lf_down_i   <= !up;
            lf_coarse_i <= coarse;
            @(posedge mclk_i);
            lf_up_i     <= 1'b0;
            lf_down_i   <= 1'b0;
        end
        #1;
    endtask : step

    task automatic frame(input logic [4:0] nom, output int lng, output int hlf);
        lng = 0;
        hlf = 0;
        repeat (32) begin
            @(posedge mclk_i);
            ring_tick_i <= 1'b1;
            @(posedge mclk_i);
            ring_tick_i <= 1'b0;
            @(posedge mclk_i);
            #1;
            lng += int'(ring_stages_o !== nom);
            hlf += int'(ring_half_o === 1'b1);
        end
    endtask : frame

    task automatic wait_sel(input logic v);
        int n;
        n = 0;
        while (osc_sel_ext_o !== v && n < 2000) begin
            @(posedge mclk_i);
            n++;
        end
        #1;
        chk({7'h0, osc_sel_ext_o}, {7'h0, v});
        if (osc_sel_ext_o !== v) end_of_test();
    endtask : wait_sel

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        // internal stable is still inside the synchroniser on this read
        rchk(`CMDC_OFF_CTRL, 8'h01);
        rchk(`CMDC_OFF_CTRL, 8'h03);
        chk({5'h0, int_gen_on_o, osc_sel_ext_o, timebase_sel_ext_o},
            8'h04);
        rchk(`CMDC_OFF_MULT, 8'h15);
        wr(`CMDC_OFF_MULT, 8'h54);
        chk({1'b0, multiply_factor_o}, 8'h54);
        wr(4'h2, 8'hff);
        rchk(4'h2, 8'h00);
        rchk(`CMDC_OFF_MULT, 8'h54);
    endtask : t_regs

    task automatic t_monitor();
        logic [7:0] d;
        int n;
        wr(`CMDC_OFF_CTRL, 8'h31);
        rchk(`CMDC_OFF_CTRL, 8'h03);
        @(posedge mclk_i) ext_stab_done_i <= 1'b1;
        wr(`CMDC_OFF_CTRL, 8'h05);
        repeat (4) @(posedge mclk_i);
        rchk(`CMDC_OFF_CTRL, 8'h0f);
        wr(`CMDC_OFF_CTRL, 8'h15);
        chk({6'h0, osc_sel_ext_o, timebase_sel_ext_o}, 8'h03);
        wr(`CMDC_OFF_CTRL, 8'hb5);
        rchk(`CMDC_OFF_CTRL, 8'hbf);
        @(posedge mclk_i) ext_stab_done_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        rchk(`CMDC_OFF_CTRL, 8'hb7);
        @(posedge mclk_i) ext_stab_done_i <= 1'b1;
        ext_run = 1'b0;
        wait_sel(1'b0);
        chk({7'h0, timebase_sel_ext_o}, 8'h00);
        chk({7'h0, monitor_irq_o}, 8'h01);
        rchk(`CMDC_OFF_STAT, 8'h02);
        ext_run = 1'b1;
        n = 0;
        do begin
            rd(`CMDC_OFF_STAT, d);
            n++;
        end while (d[1] !== 1'b0 && n < 200);
        chk(d, 8'h00);
        if (d[1] !== 1'b0) end_of_test();
        wr(`CMDC_OFF_CTRL, 8'ha5);
        chk({7'h0, monitor_irq_o}, 8'h01);
        rchk(`CMDC_OFF_CTRL, 8'hef);
        wr(`CMDC_OFF_CTRL, 8'he5);
        chk({7'h0, monitor_irq_o}, 8'h01);
        wr(`CMDC_OFF_CTRL, 8'h85);
        rchk(`CMDC_OFF_CTRL, 8'h8f);
        wr(`CMDC_OFF_CTRL, 8'ha5);
        base_run = 1'b0;
        wait_sel(1'b1);
        chk({7'h0, monitor_irq_o}, 8'h01);
        base_run = 1'b1;
    endtask : t_monitor

    task automatic t_dco();
        logic [7:0] d;
        int l, h;
        step(1'b1, 1'b1, 3);
        rchk(`CMDC_OFF_DCO, 8'h60);
        chk({3'h0, ring_stages_o}, 8'd23);
        step(1'b1, 1'b0, 1);
        frame(5'd23, l, h);
        chk(l[7:0], 8'h01);
        step(1'b1, 1'b1, 4);
        frame(5'd31, l, h);
        chk({l[3:0], h[3:0]}, 8'h11);
        step(1'b1, 1'b1, 1);
        rd(`CMDC_OFF_STAT, d);
        chk({4'h0, d[5:2]}, 8'h01);
        step(1'b0, 1'b0, 2);
        rchk(`CMDC_OFF_DCO, 8'hff);
        rd(`CMDC_OFF_STAT, d);
        chk({4'h0, d[5:2]}, 8'h00);
        step(1'b1, 1'b1, 80);
        rd(`CMDC_OFF_STAT, d);
        chk({d[5:2], divider_shift_o}, 8'h99);
        rchk(`CMDC_OFF_DCO, 8'hff);
    endtask : t_dco

    initial begin
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_regs();
        t_monitor();
        t_dco();
        end_of_test();
    end
endmodule : cmdc_clock_monitor_tb
